// *** rtl/tic_defines.vh ***
// Constants for the time interval counter: register addresses, fields, resets and timing.
// Operation
// - Hours wrap at 23 or 255 by bit 6.
// - Bits 5:4 pick interval step timebase.
// - One-shot mode clears interval enable on timeout.
// - Otherwise interval counter reloads and keeps counting.
// - Match sets flag; only software write clears.
// - Flag drives interrupt request, gated by enable.
// - Bit 1 starts and stops interval counter.
// - Bit 0 gates the tick; else only the prescaler advances.
// - Clearing bit 0 restores last written time.
// - Time registers load while clock is disabled.
// - Eight-bit writable interval match value.
// - Fine tick counts 0-127, carries into seconds.
// - Seconds count 0-59, carry into minutes.
// - Minutes count 0-59, carry into hours.
// - Hours advance hourly and roll over.
// - Control bit 7 ignored, reads zero.
// - Each step of the selected register clocks interval counter.
// - Counters run from crystal, also in power-down.
// - Enabled flag in power-down wakes the core.
`ifndef TIC_DEFINES_VH
`define TIC_DEFINES_VH

`define TIC_ADDR_CONTROL      8'ha1
`define TIC_ADDR_FINE         8'ha2
`define TIC_ADDR_SEC          8'ha3
`define TIC_ADDR_MIN          8'ha4
`define TIC_ADDR_HOUR         8'ha5
`define TIC_ADDR_MATCH        8'ha6

`define TIC_BIT_DAY_WRAP      6
`define TIC_BIT_TB_HI         5
`define TIC_BIT_TB_LO         4
`define TIC_BIT_ONE_SHOT      3
`define TIC_BIT_FLAG          2
`define TIC_BIT_INTERVAL_ON   1
`define TIC_BIT_CLOCK_ON      0

`define TIC_TB_FINE           2'h0
`define TIC_TB_SEC            2'h1
`define TIC_TB_MIN            2'h2
`define TIC_TB_HOUR           2'h3

`define TIC_RESET_VALUE       8'h00
`define TIC_FINE_MAX          8'h7f
`define TIC_SEC_MAX           8'h3b
`define TIC_MIN_MAX           8'h3b
`define TIC_HOUR_MAX_DAY      8'h17
`define TIC_HOUR_MAX_FULL     8'hff

`define TIC_XTAL_HZ           32768
`define TIC_TICKS_PER_SEC     128
`define TIC_XTAL_PER_TICK     (`TIC_XTAL_HZ / `TIC_TICKS_PER_SEC)

`endif

// *** rtl/tic_wrap_counter.v ***
// One loadable wrap-around counter stage of the time cascade.
`default_nettype none
module tic_wrap_counter #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input  wire             clk_in,
   input  wire             reset_n_in,
   // Control
   input  wire             load_in,
   input  wire [WIDTH-1:0] load_value_in,
   input  wire             step_in,
   input  wire [WIDTH-1:0] limit_in,
   // State
   output reg  [WIDTH-1:0] count_out,
   output wire             carry_out
);

   // A value above the limit, left by a mode change, also wraps so it can never run away.
   wire at_limit = (count_out >= limit_in);

   assign carry_out = step_in & ~load_in & at_limit;

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_out <= {WIDTH{1'b0}};
      end else if (load_in) begin
         count_out <= load_value_in;
      end else if (step_in) begin
         if (at_limit) begin
            count_out <= {WIDTH{1'b0}};
         end else begin
            count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule
`default_nettype wire

// *** rtl/tic_top.v ***
// Time interval counter and real-time clock behind the core's special function register bus.
`include "tic_defines.vh"
`default_nettype none
module tic_top #(
   parameter XTAL_PER_TICK = `TIC_XTAL_PER_TICK
) (
   // Clock and reset
   input  wire       clk_in,
   input  wire       reset_n_in,
   // Crystal reference
   input  wire       xtal_in,
   // Special function register bus
   input  wire [7:0] sfr_addr_in,
   input  wire       sfr_wr_in,
   input  wire       sfr_rd_in,
   input  wire [7:0] sfr_wdata_in,
   output reg  [7:0] sfr_rdata_out,
   output reg        sfr_hit_out,
   // Core status
   input  wire       irq_enable_in,
   input  wire       power_down_in,
   // Requests to the core
   output reg        irq_out,
   output reg        wake_out
);

   // Control register fields, match value and interval count.
   reg        day_wrap_select;
   reg [1:0]  timebase_select;
   reg        one_shot_select;
   reg        interval_match_flag;
   reg        interval_counter_on;
   reg        time_clock_on;
   reg [7:0]  interval_match_value;
   reg [7:0]  interval_count;

   // Last values software wrote to the time registers.
   reg [7:0]  shadow_fine;
   reg [7:0]  shadow_sec;
   reg [7:0]  shadow_min;
   reg [7:0]  shadow_hour;

   // Crystal edge detection and tick prescaler.
   reg        xtal_meta;
   reg        xtal_sync;
   reg        xtal_prev;
   reg [15:0] xtal_count;

   wire        xtal_rise = xtal_sync & ~xtal_prev;
   // The prescaler is 16 bits wide, so a divide above 65536 is not supported.
   wire [31:0] xtal_last_full = XTAL_PER_TICK - 1;
   wire [15:0] xtal_last = xtal_last_full[15:0];
   wire        raw_tick  = xtal_rise & (xtal_count == xtal_last);
   wire        tick      = raw_tick & time_clock_on;

   // Register decode.
   wire wr_ctl   = sfr_wr_in & (sfr_addr_in == `TIC_ADDR_CONTROL);
   wire wr_fine  = sfr_wr_in & (sfr_addr_in == `TIC_ADDR_FINE);
   wire wr_sec   = sfr_wr_in & (sfr_addr_in == `TIC_ADDR_SEC);
   wire wr_min   = sfr_wr_in & (sfr_addr_in == `TIC_ADDR_MIN);
   wire wr_hour  = sfr_wr_in & (sfr_addr_in == `TIC_ADDR_HOUR);
   wire wr_match = sfr_wr_in & (sfr_addr_in == `TIC_ADDR_MATCH);

   // Cascade counters.
   wire [7:0] fine_tick_count;
   wire [7:0] time_s_count;
   wire [7:0] time_m_count;
   wire [7:0] hour_count;
   wire       fine_carry;
   wire       sec_carry;
   wire       min_carry;

   // While the clock is off every stage follows its shadow, so stopping it discards accumulated counts.
   wire load_fine = wr_fine | ~time_clock_on;
   wire load_sec  = wr_sec  | ~time_clock_on;
   wire load_min  = wr_min  | ~time_clock_on;
   wire load_hour = wr_hour | ~time_clock_on;

   wire [7:0] fine_load_value = wr_fine ? sfr_wdata_in : shadow_fine;
   wire [7:0] sec_load_value  = wr_sec  ? sfr_wdata_in : shadow_sec;
   wire [7:0] min_load_value  = wr_min  ? sfr_wdata_in : shadow_min;
   wire [7:0] hour_load_value = wr_hour ? sfr_wdata_in : shadow_hour;

   wire [7:0] hour_limit = day_wrap_select ? `TIC_HOUR_MAX_DAY : `TIC_HOUR_MAX_FULL;

   wire [7:0] fine_limit = `TIC_FINE_MAX;
   wire [7:0] sec_limit  = `TIC_SEC_MAX;
   wire [7:0] min_limit  = `TIC_MIN_MAX;

   tic_wrap_counter #(.WIDTH(8)) u_fine (
      .clk_in        (clk_in),
      .reset_n_in    (reset_n_in),
      .load_in       (load_fine),
      .load_value_in (fine_load_value),
      .step_in       (tick),
      .limit_in      (fine_limit),
      .count_out     (fine_tick_count),
      .carry_out     (fine_carry)
   );

   tic_wrap_counter #(.WIDTH(8)) u_sec (
      .clk_in        (clk_in),
      .reset_n_in    (reset_n_in),
      .load_in       (load_sec),
      .load_value_in (sec_load_value),
      .step_in       (fine_carry),
      .limit_in      (sec_limit),
      .count_out     (time_s_count),
      .carry_out     (sec_carry)
   );

   tic_wrap_counter #(.WIDTH(8)) u_min (
      .clk_in        (clk_in),
      .reset_n_in    (reset_n_in),
      .load_in       (load_min),
      .load_value_in (min_load_value),
      .step_in       (sec_carry),
      .limit_in      (min_limit),
      .count_out     (time_m_count),
      .carry_out     (min_carry)
   );

   tic_wrap_counter #(.WIDTH(8)) u_hour (
      .clk_in        (clk_in),
      .reset_n_in    (reset_n_in),
      .load_in       (load_hour),
      .load_value_in (hour_load_value),
      .step_in       (min_carry),
      .limit_in      (hour_limit),
      .count_out     (hour_count),
      .carry_out     ()
   );

   // Interval step chosen by the timebase field.
   reg interval_step;
   always @* begin
      case (timebase_select)
         `TIC_TB_FINE: interval_step = tick;
         `TIC_TB_SEC:  interval_step = fine_carry;
         `TIC_TB_MIN:  interval_step = sec_carry;
         default:      interval_step = min_carry;
      endcase
   end

   wire       interval_advance = interval_step & interval_counter_on & time_clock_on;
   wire [7:0] interval_next    = interval_count + 8'h01;
   wire       interval_timeout = interval_advance & (interval_next == interval_match_value);

   // Crystal sampling: the first stage feeds only the second.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         xtal_meta <= 1'b0;
         xtal_sync <= 1'b0;
         xtal_prev <= 1'b0;
      end else begin
         xtal_meta <= xtal_in;
         xtal_sync <= xtal_meta;
         xtal_prev <= xtal_sync;
      end
   end

   // The prescaler never stops, power-down or not, so long sleeps stay timed.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         xtal_count <= 16'h0000;
      end else if (xtal_rise) begin
         if (xtal_count == xtal_last) begin
            xtal_count <= 16'h0000;
         end else begin
            xtal_count <= xtal_count + 16'h0001;
         end
      end
   end

   // Shadow copies and match value.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         shadow_fine          <= `TIC_RESET_VALUE;
         shadow_sec           <= `TIC_RESET_VALUE;
         shadow_min           <= `TIC_RESET_VALUE;
         shadow_hour          <= `TIC_RESET_VALUE;
         interval_match_value <= `TIC_RESET_VALUE;
      end else begin
         if (wr_fine) begin
            shadow_fine <= sfr_wdata_in;
         end
         if (wr_sec) begin
            shadow_sec <= sfr_wdata_in;
         end
         if (wr_min) begin
            shadow_min <= sfr_wdata_in;
         end
         if (wr_hour) begin
            shadow_hour <= sfr_wdata_in;
         end
         if (wr_match) begin
            interval_match_value <= sfr_wdata_in;
         end
      end
   end

   // Control register fields written by software.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         day_wrap_select     <= 1'b0;
         timebase_select     <= 2'h0;
         one_shot_select     <= 1'b0;
         interval_counter_on <= 1'b0;
         time_clock_on       <= 1'b0;
      end else begin
         if (wr_ctl) begin
            // Bit 7 has no storage.
            day_wrap_select <= sfr_wdata_in[`TIC_BIT_DAY_WRAP];
            timebase_select <= sfr_wdata_in[`TIC_BIT_TB_HI:`TIC_BIT_TB_LO];
            one_shot_select <= sfr_wdata_in[`TIC_BIT_ONE_SHOT];
            time_clock_on   <= sfr_wdata_in[`TIC_BIT_CLOCK_ON];
         end
         // A software write to the enable wins over a one-shot clear in the same cycle.
         if (wr_ctl) begin
            interval_counter_on <= sfr_wdata_in[`TIC_BIT_INTERVAL_ON];
         end else if (interval_timeout && one_shot_select) begin
            interval_counter_on <= 1'b0;
         end
      end
   end

   // A match in the same cycle as a clearing write still leaves the flag set.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         interval_match_flag <= 1'b0;
      end else if (interval_timeout) begin
         interval_match_flag <= 1'b1;
      end else if (wr_ctl && !sfr_wdata_in[`TIC_BIT_FLAG]) begin
         interval_match_flag <= 1'b0;
      end
   end

   // Held at zero while disabled, so every fresh start counts a full interval.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         interval_count <= 8'h00;
      end else if (!interval_counter_on) begin
         interval_count <= 8'h00;
      end else if (interval_timeout) begin
         interval_count <= 8'h00;
      end else if (interval_advance) begin
         interval_count <= interval_next;
      end
   end

   // Register read-back and requests to the core.
   wire [7:0] control_view = {1'b0, day_wrap_select, timebase_select, one_shot_select,
                              interval_match_flag, interval_counter_on, time_clock_on};

   // Read decode: an unmapped address returns zero with no hit.
   reg  [7:0] next_rdata;
   reg        next_hit;
   always @* begin
      next_rdata = 8'h00;
      next_hit   = 1'b0;
      if (sfr_addr_in == `TIC_ADDR_CONTROL) begin
         next_rdata = control_view;
         next_hit   = 1'b1;
      end else if (sfr_addr_in == `TIC_ADDR_FINE) begin
         next_rdata = fine_tick_count;
         next_hit   = 1'b1;
      end else if (sfr_addr_in == `TIC_ADDR_SEC) begin
         next_rdata = time_s_count;
         next_hit   = 1'b1;
      end else if (sfr_addr_in == `TIC_ADDR_MIN) begin
         next_rdata = time_m_count;
         next_hit   = 1'b1;
      end else if (sfr_addr_in == `TIC_ADDR_HOUR) begin
         next_rdata = hour_count;
         next_hit   = 1'b1;
      end else if (sfr_addr_in == `TIC_ADDR_MATCH) begin
         next_rdata = interval_match_value;
         next_hit   = 1'b1;
      end
   end

   // Single clock domain: the core sees whole, settled values with no crossing to tear them.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sfr_rdata_out <= 8'h00;
         sfr_hit_out   <= 1'b0;
      end else begin
         sfr_hit_out <= sfr_rd_in & next_hit;
         if (sfr_rd_in) begin
            sfr_rdata_out <= next_rdata;
         end
      end
   end

   // Requests leave from flip-flops so the core never sees a glitch on them.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_out  <= 1'b0;
         wake_out <= 1'b0;
      end else begin
         irq_out  <= interval_match_flag & irq_enable_in;
         wake_out <= interval_match_flag & irq_enable_in & power_down_in;
      end
   end

endmodule
`default_nettype wire

// *** tb/tic_top_sva.sv ***
// Port checks for the time interval counter.
`default_nettype none
module tic_top_sva #(
   parameter XTAL_PER_TICK = 256
) (
   // Clock and reset
   input wire logic       clk_in,
   input wire logic       reset_n_in,
   // Watched ports
   input wire logic       xtal_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic       sfr_wr_in,
   input wire logic       sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic       sfr_hit_out,
   input wire logic       irq_enable_in,
   input wire logic       power_down_in,
   input wire logic       irq_out,
   input wire logic       wake_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   wire logic mapped = sfr_addr_in >= 8'ha1 && sfr_addr_in <= 8'ha6;
   wire logic ctl_wr = sfr_wr_in && sfr_addr_in == 8'ha1 && !sfr_wdata_in[2];
   AST_HIT_DECODE: assert property (sfr_hit_out == ($past(sfr_rd_in) && $past(mapped)))
      else $error("hit strobe wrong");
   AST_UNMAPPED_ZERO: assert property ($past(sfr_rd_in) && !$past(mapped) |-> sfr_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   AST_RDATA_HOLD: assert property (!$past(sfr_rd_in) |-> $stable(sfr_rdata_out))
      else $error("read data moved");
   AST_BIT7_ZERO: assert property ($past(sfr_rd_in) && $past(sfr_addr_in) == 8'ha1 |-> !sfr_rdata_out[7])
      else $error("control bit 7 set");
   AST_MATCH_RW: assert property ($past(sfr_wr_in, 3) && $past(sfr_addr_in, 3) == 8'ha6 && $past(sfr_rd_in)
      && !$past(sfr_wr_in, 2) && $past(sfr_addr_in) == 8'ha6 |-> sfr_rdata_out == $past(sfr_wdata_in, 3))
      else $error("match value lost");
   AST_IRQ_GATED: assert property (irq_out |-> $past(irq_enable_in))
      else $error("request while disabled");
   AST_WAKE_COND: assert property (wake_out |-> irq_out && $past(power_down_in))
      else $error("wake without cause");
   AST_WAKE_GIVEN: assert property (irq_out && $past(power_down_in) |-> wake_out)
      else $error("wake missing");
   AST_FLAG_CLEAR: assert property ($fell(irq_out) |-> !$past(irq_enable_in) || !$past(irq_enable_in, 2)
      || $past(ctl_wr) || $past(ctl_wr, 2))
      else $error("flag dropped without write");
   COV_IRQ: cover property ($rose(irq_out));
   COV_WAKE: cover property (wake_out);
   COV_HIT: cover property (sfr_hit_out);
endmodule
`default_nettype wire

// *** tb/tic_core_model.sv ***
// Core model driving the special function register bus.
`default_nettype none
module tic_core_model (
   // Clock
   input  wire logic       clk_in,
   // Register bus
   output var  logic [7:0] sfr_addr_out,
   output var  logic       sfr_wr_out,
   output var  logic       sfr_rd_out,
   output var  logic [7:0] sfr_wdata_out,
   input  wire logic [7:0] sfr_rdata_in,
   input  wire logic       sfr_hit_in,
   // Core status
   output var  logic       irq_enable_out,
   output var  logic       power_down_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sfr_addr_out = 8'h00;
      sfr_wr_out = 1'b0;
      sfr_rd_out = 1'b0;
      sfr_wdata_out = 8'h00;
      irq_enable_out = 1'b1;
      power_down_out = 1'b1;
   end
   // Enter at a falling edge; released data shows its inverse so stale values never match.
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_out = a;
      sfr_wdata_out = d;
      sfr_wr_out = 1'b1;
      @(posedge clk_in);
      @(negedge clk_in);
      sfr_wr_out = 1'b0;
      sfr_wdata_out = ~d;
      sfr_addr_out = ~a;
      // One idle cycle keeps back-to-back calls from driving a strobe twice in one step.
      @(negedge clk_in);
   endtask
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d, output logic h);
      sfr_addr_out = a;
      sfr_rd_out = 1'b1;
      @(posedge clk_in);
      @(negedge clk_in);
      sfr_rd_out = 1'b0;
      d = sfr_rdata_in;
      h = sfr_hit_in;
      sfr_addr_out = ~a;
      @(negedge clk_in);
   endtask
endmodule
`default_nettype wire

// *** tb/time_interval_counter_tb_top.sv ***
// Self-checking bench for the time interval counter.
`default_nettype none
module time_interval_counter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_in = 1'b0;
   logic       reset_n_in = 1'b0;
   logic       xtal = 1'b0;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       wr;
   logic       rd;
   logic       hit;
   logic       irq_en;
   logic       pdown;
   logic       irq;
   logic       wake;
   int         n_errors = 0;
   int         comparisons = 0;
   logic [7:0] hs [3] = '{8'h17, 8'h17, 8'hff};
   logic [7:0] hc [3] = '{8'h41, 8'h01, 8'h01};
   logic [7:0] he [3] = '{8'h00, 8'h18, 8'h00};
   always #10 clk_in = ~clk_in;
   // Crystal is free running and unrelated in phase to the system clock.
   always #73 xtal = ~xtal;
   tic_top #(.XTAL_PER_TICK(2)) dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .xtal_in(xtal),
      .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
      .sfr_hit_out(hit), .irq_enable_in(irq_en), .power_down_in(pdown), .irq_out(irq), .wake_out(wake));
   tic_core_model core_u (.clk_in(clk_in), .sfr_addr_out(addr), .sfr_wr_out(wr), .sfr_rd_out(rd),
      .sfr_wdata_out(wdata), .sfr_rdata_in(rdata), .sfr_hit_in(hit), .irq_enable_out(irq_en),
      .power_down_out(pdown));
   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      core_u.sfr_write(a, d);
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       h;
      core_u.sfr_read(a, d, h);
      cmp($sformatf("reg %h", a), e, d);
      cmp("hit", {7'h00, a >= 8'ha1 && a <= 8'ha6}, {7'h00, h});
   endtask
   task automatic pause(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic wait_irq();
      int i;
      for (i = 0; i < 100 && irq !== 1'b1; i++) @(negedge clk_in);
      if (irq !== 1'b1) begin
         n_errors++;
         $display("wrong value irq wait expected 1 seen %b", irq);
         give_verdict();
      end
   endtask
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #1ms;
      n_errors++;
      give_verdict();
   end
   initial begin
      int a;
      int t;
      pause(6);
      reset_n_in = 1'b1;
      for (a = 8'ha1; a <= 8'ha7; a++) chk(a[7:0], 8'h00);
      put(8'ha6, 8'hff);
      chk(8'ha6, 8'hff);
      put(8'ha1, 8'h80);
      chk(8'ha1, 8'h00);
      put(8'ha2, 8'h7f);
      put(8'ha3, 8'h3b);
      put(8'ha4, 8'h3b);
      pause(40);
      chk(8'ha2, 8'h7f);
      for (t = 0; t < 3; t++) begin
         put(8'ha5, hs[t]);
         put(8'ha1, hc[t]);
         pause(40);
         chk(8'ha3, 8'h00);
         chk(8'ha4, 8'h00);
         chk(8'ha5, he[t]);
         put(8'ha1, 8'h00);
         chk(8'ha3, 8'h3b);
      end
      put(8'ha2, 8'h10);
      put(8'ha6, 8'h01);
      put(8'ha1, 8'h1b);
      pause(40);
      chk(8'ha1, 8'h1b);
      put(8'ha1, 8'h01);
      pause(40);
      chk(8'ha1, 8'h01);
      put(8'ha1, 8'h00);
      put(8'ha2, 8'h7f);
      for (t = 0; t < 4; t++) begin
         put(8'ha1, {2'b00, t[1:0], 4'hb});
         wait_irq();
         chk(8'ha1, {2'b00, t[1:0], 4'hd});
         cmp("wake", 8'h01, {7'h00, wake});
         put(8'ha1, 8'h00);
         pause(3);
         cmp("irq", 8'h00, {7'h00, irq});
      end
      put(8'ha6, 8'h02);
      put(8'ha1, 8'h03);
      wait_irq();
      chk(8'ha1, 8'h07);
      core_u.power_down_out = 1'b0;
      pause(3);
      cmp("wake", 8'h00, {7'h00, wake});
      core_u.power_down_out = 1'b1;
      core_u.irq_enable_out = 1'b0;
      pause(3);
      cmp("irq", 8'h00, {7'h00, irq});
      put(8'ha1, 8'h03);
      core_u.irq_enable_out = 1'b1;
      wait_irq();
      give_verdict();
   end
endmodule
bind tic_top tic_top_sva #(.XTAL_PER_TICK(XTAL_PER_TICK)) sva_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .xtal_in(xtal_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
   .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out),
   .irq_enable_in(irq_enable_in), .power_down_in(power_down_in), .irq_out(irq_out), .wake_out(wake_out));
`default_nettype wire
